// File: dsw_regs.svh
// Constants for the switch-bank setup interpreter
`ifndef DSW_REGS_SVH
`define DSW_REGS_SVH
// Register byte offsets
`define DSW_OFS_STATUS  8'h00
`define DSW_OFS_MASK    8'h04
`define DSW_OFS_CTRL    8'h08
`define DSW_OFS_CONFIG  8'h0C
`define DSW_OFS_SWITCH  8'h10
// Status and mask bit positions
`define DSW_EV_GOOD     0
`define DSW_EV_ERROR    1
`define DSW_EV_FACTORY  2
`define DSW_EV_PASS     3
`define DSW_EV_ARCHIVE  4
`define DSW_EV_W        5
// Control bit positions and reset values
`define DSW_CTRL_EXECEN 0
`define DSW_CTRL_RST    1'h1
`define DSW_MASK_RST    5'h00
// Mode switch codes
`define DSW_MODE_RUN    5'h00
`define DSW_MODE_DIRECT 5'h01
`define DSW_MODE_SOURCE 5'h02
`define DSW_MODE_TRAVEL 5'h03
// Direct command codes
`define DSW_CMD_FACTORY 8'h01
`define DSW_CMD_PASS    8'h02
`define DSW_CMD_ARCHIVE 8'h03
// Reserved station addresses
`define DSW_ADDR_BCAST0 8'h00
`define DSW_ADDR_BCAST1 8'hFF
// Highest legal code of source and travel settings
`define DSW_SRC_MAX     8'h05
`define DSW_TRAV_MAX    8'h03
// Reset value of every setup entry, and factory reload value of every entry but entry 0
`define DSW_DFLT_VAL    8'h00
`define DSW_CFG_DEPTH   32
// Timing in ms and clock rate in MHz
`define DSW_CLK_MHZ     100
`define DSW_DEB_MS      10
`define DSW_FAST_MS     50
`define DSW_SLOW_MS     500
`define DSW_GOOD_MS     1000
`define DSW_MS_CYC(ms)  ((ms) * 1000 * `DSW_CLK_MHZ)
`endif

// File: dsw_pkg.sv
// Types for the switch-bank setup interpreter
package dsw_pkg;
  typedef enum logic {DSW_RUN, DSW_SETUP} dsw_state_t;
  typedef enum logic [2:0] {
    DSW_SRC_HOST, DSW_SRC_AIN_TORQUE, DSW_SRC_AIN_USER1,
    DSW_SRC_AIN_USER2, DSW_SRC_BLOCK, DSW_SRC_PULSE
  } dsw_src_t;
endpackage

// File: dsw_setup.sv
// Switch-bank setup interpreter with APB status and control
`timescale 1ns/10ps
`include "dsw_regs.svh"

module dsw_setup #(
  parameter int unsigned DEB_CYC  = `DSW_MS_CYC(`DSW_DEB_MS),
  parameter int unsigned FAST_CYC = `DSW_MS_CYC(`DSW_FAST_MS),
  parameter int unsigned SLOW_CYC = `DSW_MS_CYC(`DSW_SLOW_MS),
  parameter int unsigned GOOD_CYC = `DSW_MS_CYC(`DSW_GOOD_MS)
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [4:0]  modeSwitchBank,
  input  wire logic [7:0]  parameterSwitchBank,
  input  wire logic        selectorOff,
  input  wire logic        executeButton,
  input  wire logic        userInputOne,
  input  wire logic        userInputTwo,
  output logic             irq,
  output logic             healthLed,
  output logic             goodLed,
  output logic             errorLed,
  output logic             inSetup,
  output logic [7:0]       stationAddr,
  output logic [2:0]       controlSource,
  output logic             closeOnTorque,
  output logic             openOnTorque,
  output logic             valveOpenDrive,
  output logic             valveCloseDrive,
  output logic             factoryLoad,
  output logic             passcodeClear,
  output logic             torqueArchive,
  output logic             cfgWrite,
  output logic [4:0]       cfgIndex,
  output logic [7:0]       cfgData
);

  // Two-flop synchronisers for the switch, selector, button and user-input pins
  localparam int SW = 17;
  logic [SW-1:0] pinMeta_r;
  logic [SW-1:0] pinSync_r;
  wire  [SW-1:0] pinRaw = {userInputTwo, userInputOne, executeButton, selectorOff,
                           modeSwitchBank, parameterSwitchBank};
  always_ff @(posedge core_clk) begin
    pinMeta_r <= reset_n ? pinRaw : '0;
    pinSync_r <= reset_n ? pinMeta_r : '0;
  end
  wire [7:0] paramSync = pinSync_r[7:0];
  wire [4:0] modeSync  = pinSync_r[12:8];
  wire       selOff    = pinSync_r[13];
  wire       execSync  = pinSync_r[14];
  wire       userOne   = pinSync_r[15];
  wire       userTwo   = pinSync_r[16];

  logic [31:0] debCnt_r;
  logic        execStable_r;
  logic        execPress_r;
  wire         execDiff  = execSync != execStable_r;
  wire         debDone   = debCnt_r >= DEB_CYC - 1;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      debCnt_r     <= '0;
      execStable_r <= 1'b0;
      execPress_r  <= 1'b0;
    end else begin
      debCnt_r     <= (execDiff && !debDone) ? debCnt_r + 32'h1 : '0;
      execStable_r <= (execDiff && debDone) ? execSync : execStable_r;
      execPress_r  <= execDiff && debDone && execSync;
    end
  end

  // Bus registers
  logic [`DSW_EV_W-1:0] status_r;
  logic [`DSW_EV_W-1:0] mask_r;
  logic                 execEn_r;
  dsw_pkg::dsw_state_t  state_r;

  // act on the press, banks sampled at that cycle
  wire press = execPress_r && selOff && execEn_r;
  // mode bank picks target, parameter bank gives data
  wire isRun    = modeSync == `DSW_MODE_RUN;
  wire isDirect = modeSync == `DSW_MODE_DIRECT;
  wire isSource = modeSync == `DSW_MODE_SOURCE;
  wire isTravel = modeSync == `DSW_MODE_TRAVEL;
  wire addrOk   = paramSync != `DSW_ADDR_BCAST0 && paramSync != `DSW_ADDR_BCAST1;
  wire cmdFact  = paramSync == `DSW_CMD_FACTORY;
  wire cmdPass  = paramSync == `DSW_CMD_PASS;
  wire cmdArch  = paramSync == `DSW_CMD_ARCHIVE;
  wire cmdOk    = cmdFact || cmdPass || cmdArch;
  wire srcOk    = paramSync <= `DSW_SRC_MAX;
  wire travOk   = paramSync <= `DSW_TRAV_MAX;
  wire entryOk  = isRun ? addrOk : isDirect ? cmdOk : isSource ? srcOk :
                  isTravel ? travOk : 1'b1;
  wire evGood   = press && entryOk;
  wire evErr    = press && !entryOk;
  // direct commands do not store, every other good entry does
  wire doStore  = evGood && !isDirect;
  wire evFact   = evGood && isDirect && cmdFact;
  wire evPass   = evGood && isDirect && cmdPass;
  wire evArch   = evGood && isDirect && cmdArch;
  wire [`DSW_EV_W-1:0] events = {evArch, evPass, evFact, evErr, evGood};

  // Configuration memory, one byte per mode code
  logic [7:0] cfgMem_r [`DSW_CFG_DEPTH];
  genvar gi;
  generate
    for (gi = 0; gi < `DSW_CFG_DEPTH; gi++) begin : g_cfg
      // raw parameter byte stored as is
      always_ff @(posedge core_clk) begin
        if (!reset_n)
          cfgMem_r[gi] <= `DSW_DFLT_VAL;
        else if (doStore && modeSync == 5'(gi))
          cfgMem_r[gi] <= paramSync;
        else if (evFact && gi != 0)
          cfgMem_r[gi] <= `DSW_DFLT_VAL;
      end
    end
  endgenerate

  // Setup state: run on mode zero, enter, leave
  wire enterSetup = selOff && !isRun;
  wire leaveSetup = doStore && isRun;
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      state_r <= dsw_pkg::DSW_RUN;
    else begin
      unique case (state_r)
        dsw_pkg::DSW_RUN:   if (enterSetup) state_r <= dsw_pkg::DSW_SETUP;
        dsw_pkg::DSW_SETUP: if (leaveSetup) state_r <= dsw_pkg::DSW_RUN;
      endcase
    end
  end
  wire setupNow = state_r == dsw_pkg::DSW_SETUP;

  // Blink timers for health and good lights
  logic [31:0] fastCnt_r;
  logic [31:0] slowCnt_r;
  logic [31:0] goodCnt_r;
  logic        fastPh_r;
  logic        slowPh_r;
  wire         fastWrap = fastCnt_r >= FAST_CYC - 1;
  wire         slowWrap = slowCnt_r >= SLOW_CYC - 1;
  wire         goodBusy = goodCnt_r != '0;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fastCnt_r <= '0;
      slowCnt_r <= '0;
      goodCnt_r <= '0;
      fastPh_r  <= 1'b0;
      slowPh_r  <= 1'b0;
    end else begin
      fastCnt_r <= fastWrap ? '0 : fastCnt_r + 32'h1;
      slowCnt_r <= slowWrap ? '0 : slowCnt_r + 32'h1;
      fastPh_r  <= fastPh_r ^ fastWrap;
      slowPh_r  <= slowPh_r ^ slowWrap;
      // good flash window restarts on each good entry
      goodCnt_r <= evGood ? GOOD_CYC : goodBusy ? goodCnt_r - 32'h1 : '0;
    end
  end

  // APB slave: one wait state, defined error on unmapped address
  wire apbAcc   = psel && penable;
  wire apbDone  = apbAcc && pready;
  wire apbWr    = apbDone && pwrite;
  wire hitStat  = paddr == `DSW_OFS_STATUS;
  wire hitMask  = paddr == `DSW_OFS_MASK;
  wire hitCtrl  = paddr == `DSW_OFS_CTRL;
  wire hitCfg   = paddr == `DSW_OFS_CONFIG;
  wire hitSw    = paddr == `DSW_OFS_SWITCH;
  wire hitAny   = hitStat || hitMask || hitCtrl || hitCfg || hitSw;
  wire [31:0] cfgWord = {11'h000, closeOnTorque, openOnTorque, controlSource,
                         cfgMem_r[`DSW_MODE_TRAVEL], stationAddr};
  wire [31:0] swWord  = {17'h00000, setupNow, selOff, modeSync, paramSync};
  wire [31:0] rdMux   = hitStat ? {27'h0000000, status_r} :
                        hitMask ? {27'h0000000, mask_r} :
                        hitCtrl ? {31'h00000000, execEn_r} :
                        hitCfg  ? cfgWord : hitSw ? swWord : 32'h00000000;
  // Set wins over a write-one clear in the same cycle
  wire [`DSW_EV_W-1:0] statClr = (apbWr && hitStat) ? pwdata[`DSW_EV_W-1:0] : '0;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pready   <= 1'b0;
      prdata   <= '0;
      pslverr  <= 1'b0;
      status_r <= '0;
      mask_r   <= `DSW_MASK_RST;
      execEn_r <= `DSW_CTRL_RST;
      irq      <= 1'b0;
    end else begin
      pready   <= apbAcc && !pready;
      prdata   <= (apbAcc && !pready && !pwrite) ? rdMux : prdata;
      pslverr  <= apbAcc && !pready && !hitAny;
      status_r <= (status_r & ~statClr) | events;
      mask_r   <= (apbWr && hitMask) ? pwdata[`DSW_EV_W-1:0] : mask_r;
      execEn_r <= (apbWr && hitCtrl) ? pwdata[`DSW_CTRL_EXECEN] : execEn_r;
      irq      <= |(status_r & mask_r);
    end
  end

  // Registered outputs from memory, state and timers
  wire pulseMode = cfgMem_r[`DSW_MODE_SOURCE][2:0] == dsw_pkg::DSW_SRC_PULSE;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      healthLed       <= 1'b0;
      goodLed         <= 1'b0;
      errorLed        <= 1'b0;
      inSetup         <= 1'b0;
      stationAddr     <= '0;
      controlSource   <= '0;
      closeOnTorque   <= 1'b0;
      openOnTorque    <= 1'b0;
      valveOpenDrive  <= 1'b0;
      valveCloseDrive <= 1'b0;
      factoryLoad     <= 1'b0;
      passcodeClear   <= 1'b0;
      torqueArchive   <= 1'b0;
      cfgWrite        <= 1'b0;
      cfgIndex        <= '0;
      cfgData         <= '0;
    end else begin
      // fast flash in setup, slow otherwise
      healthLed       <= setupNow ? fastPh_r : slowPh_r;
      // good flashes, error held until a good entry
      goodLed         <= goodBusy && fastPh_r;
      errorLed        <= evErr ? 1'b1 : evGood ? 1'b0 : errorLed;
      inSetup         <= setupNow;
      stationAddr     <= cfgMem_r[`DSW_MODE_RUN];
      controlSource   <= cfgMem_r[`DSW_MODE_SOURCE][2:0];
      // bit 0 close on torque seat, bit 1 open on backseat
      closeOnTorque   <= cfgMem_r[`DSW_MODE_TRAVEL][0];
      openOnTorque    <= cfgMem_r[`DSW_MODE_TRAVEL][1];
      valveOpenDrive  <= pulseMode && userOne;
      valveCloseDrive <= pulseMode && userTwo;
      factoryLoad     <= evFact;
      passcodeClear   <= evPass;
      torqueArchive   <= evArch;
      cfgWrite        <= doStore;
      cfgIndex        <= doStore ? modeSync : cfgIndex;
      cfgData         <= doStore ? paramSync : cfgData;
    end
  end

  // Checks on the interpreter
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  addr_store_a: assert property (press && isRun && addrOk |=> ##1
    stationAddr == $past(paramSync, 2)) else $error("address not stored");

  addr_bcast_a: assert property (press && isRun && !addrOk |=> ##1
    $stable(stationAddr) && errorLed) else $error("broadcast address taken");

  addr_keep_a: assert property (press && !isRun |=> ##1 $stable(stationAddr))
    else $error("address changed by other entry");

  store_write_a: assert property (press && entryOk && !isDirect |=> cfgWrite
    && cfgData == $past(paramSync)) else $error("store strobe missing");

  direct_nostore_a: assert property (press && isDirect |=> !cfgWrite)
    else $error("direct command stored");

  err_hold_a: assert property (errorLed && !evGood |=> errorLed)
    else $error("error light dropped");

  good_clear_a: assert property (evGood |=> !errorLed)
    else $error("error light not cleared");

  bad_entry_a: assert property (evErr |=> errorLed && !cfgWrite)
    else $error("bad entry not flagged");

  err_status_a: assert property (evErr |=> status_r[`DSW_EV_ERROR])
    else $error("error status not set");

  good_flash_a: assert property (evGood |=> goodBusy [*8])
    else $error("good flash too short");

  setup_enter_a: assert property (!setupNow && enterSetup |=> ##1 inSetup)
    else $error("setup not entered");

  setup_exit_a: assert property (setupNow && leaveSetup |=> ##1 !inSetup)
    else $error("setup not left");

  factory_cmd_a: assert property (press && isDirect && cmdFact |=>
    factoryLoad && !passcodeClear) else $error("factory reload missing");

  passcode_cmd_a: assert property (press && isDirect && cmdPass |=>
    passcodeClear && !torqueArchive) else $error("passcode clear missing");

  archive_cmd_a: assert property (press && isDirect && cmdArch |=>
    torqueArchive) else $error("archive missing");

  source_map_a: assert property (press && isSource && srcOk |=> ##1
    controlSource == $past(paramSync[2:0], 2)) else $error("control source wrong");

  travel_map_a: assert property (press && isTravel && travOk |=> ##1
    {openOnTorque, closeOnTorque} == $past(paramSync[1:0], 2))
    else $error("travel limit wrong");

  pulse_drive_a: assert property (pulseMode && userOne |=> valveOpenDrive)
    else $error("pulse open not driven");

  pulse_close_a: assert property (pulseMode && userTwo |=> valveCloseDrive)
    else $error("pulse close not driven");

  pulse_idle_a: assert property (!pulseMode |=> !valveOpenDrive && !valveCloseDrive)
    else $error("valve driven outside pulse mode");

  press_once_a: assert property (execPress_r |=> !execPress_r)
    else $error("press repeated");

  ignore_press_a: assert property (execPress_r && !selOff |=> !cfgWrite
    && $stable(errorLed)) else $error("press taken with selector on");

  // Interrupt follows masked status
  irq_level_a: assert property (|(status_r & mask_r) |=> irq)
    else $error("interrupt not raised");

  // Bus ready lasts one cycle
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");

  // Main scenarios
  enter_setup_c: cover property (!setupNow ##1 setupNow);
  good_entry_c:  cover property (evGood && isSource);
  bad_entry_c:   cover property (evErr ##[1:50] evGood);
  apb_read_c:    cover property (apbDone && !pwrite && hitSw);
  exit_setup_c:  cover property (setupNow ##1 !setupNow);

endmodule

// File: dsw_switch_model.sv
// Operator model: switch banks, selector, execute button and user inputs
`timescale 1ns/10ps
module dsw_switch_model #(
  parameter int HOLD = 12
) (
  input  wire logic  core_clk,
  output logic [4:0] modeSwitchBank,
  output logic [7:0] parameterSwitchBank,
  output logic       selectorOff,
  output logic       executeButton,
  output logic       userInputOne,
  output logic       userInputTwo
);
  // Quiet levels at time zero
  initial begin
    modeSwitchBank = 5'h00;
    parameterSwitchBank = 8'h00;
    selectorOff = 1'b0;
    executeButton = 1'b0;
    userInputOne = 1'b0;
    userInputTwo = 1'b0;
  end
  // Contact bounce shorter than the debounce time, then a steady level
  task automatic bounce(input logic lvl);
    repeat (2) begin
      @(posedge core_clk) executeButton <= lvl;
      @(posedge core_clk) executeButton <= ~lvl;
    end
    @(posedge core_clk) executeButton <= lvl;
    repeat (HOLD) @(posedge core_clk);
  endtask
  // banks set first
  // Banks settle before the button is pressed and released
  task automatic press(input logic [4:0] m, input logic [7:0] p);
    @(posedge core_clk);
    modeSwitchBank <= m;
    parameterSwitchBank <= p;
    repeat (HOLD) @(posedge core_clk);
    bounce(1'b1);
    bounce(1'b0);
  endtask
  // Selector and discrete user inputs
  task automatic lines(input logic s, input logic a, input logic b);
    @(posedge core_clk);
    selectorOff <= s;
    userInputOne <= a;
    userInputTwo <= b;
  endtask
endmodule

// File: tb_dsw_setup.sv
// Self-checking bench for the switch-bank setup interpreter
`timescale 1ns/10ps
`include "dsw_regs.svh"
module tb_dsw_setup;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, selectorOff, executeButton, userInputOne, userInputTwo;
  logic [4:0]  modeSwitchBank, cfgIndex;
  logic [7:0]  parameterSwitchBank, stationAddr, cfgData;
  logic [2:0]  controlSource;
  logic        irq, healthLed, goodLed, errorLed, inSetup, closeOnTorque, openOnTorque;
  logic        valveOpenDrive, valveCloseDrive, factoryLoad, passcodeClear, torqueArchive;
  logic        cfgWrite;
  logic [15:0] expq[$];
  int          num_errors = 0, checked = 0, cyc = 0, goodHigh = 0;
  localparam logic [15:0] NONE = 16'hFFFF;

  dsw_setup #(.DEB_CYC(4), .FAST_CYC(8), .SLOW_CYC(16), .GOOD_CYC(20)) i_dsw_setup (
    .core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .modeSwitchBank, .parameterSwitchBank, .selectorOff, .executeButton,
    .userInputOne, .userInputTwo, .irq, .healthLed, .goodLed, .errorLed, .inSetup,
    .stationAddr, .controlSource, .closeOnTorque, .openOnTorque, .valveOpenDrive,
    .valveCloseDrive, .factoryLoad, .passcodeClear, .torqueArchive, .cfgWrite,
    .cfgIndex, .cfgData);
  dsw_switch_model i_dsw_switch_model (
    .core_clk, .modeSwitchBank, .parameterSwitchBank, .selectorOff, .executeButton,
    .userInputOne, .userInputTwo);

  // Clock, hang guard and good-light counter
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (goodLed === 1'b1)
      goodHigh++;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("errors %0d of %0d checks", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, e);
    chk(32'(err), 32'(ee));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  // Note the expected action, then let the operator press execute
  task automatic act(input logic [4:0] m, input logic [7:0] p, input logic [15:0] e);
    if (e !== NONE)
      expq.push_back(e);
    i_dsw_switch_model.press(m, p);
  endtask
  // Cycles between two toggles of the health light
  task automatic per(input int n);
    int c;
    logic h;
    repeat (2) begin
      c = 0;
      h = healthLed;
      while (healthLed === h && c < 100) begin
        @(posedge core_clk);
        c++;
      end
    end
    chk(c, n);
  endtask

  // Compare every action pulse with the oldest note
  always @(posedge core_clk) begin
    if (reset_n && (cfgWrite | factoryLoad | passcodeClear | torqueArchive) === 1'b1)
      chk(32'({torqueArchive, passcodeClear, factoryLoad,
               cfgWrite ? {cfgIndex, cfgData} : 13'h0}),
          32'(expq.size() > 0 ? expq.pop_front() : NONE));
  end

  initial begin
    logic [7:0] r;
    logic [4:0] m;
    int g;
    r = 8'($urandom(50));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    rdchk(`DSW_OFS_MASK, 32'h0, 1'b0);
    rdchk(`DSW_OFS_CTRL, 32'h1, 1'b0);
    rdchk(`DSW_OFS_CONFIG, 32'h0, 1'b0);
    rdchk(8'h14, 32'h0, 1'b1);
    chk(32'(inSetup), 32'h0);
    i_dsw_switch_model.lines(1'b1, 1'b0, 1'b0);
    // code zero hands control to the host
    for (int p = 0; p <= 5; p++) begin
      act(`DSW_MODE_SOURCE, 8'(p), {8'h02, 8'(p)});
      chk(32'(controlSource), 32'(p));
    end
    chk(32'(inSetup), 32'h1);
    per(8);
    i_dsw_switch_model.lines(1'b1, 1'b1, 1'b0);
    repeat (4) @(posedge core_clk);
    chk(32'({valveOpenDrive, valveCloseDrive}), 32'h2);
    i_dsw_switch_model.lines(1'b1, 1'b0, 1'b1);
    repeat (4) @(posedge core_clk);
    chk(32'({valveOpenDrive, valveCloseDrive}), 32'h1);
    r = 8'(6 + $urandom_range(249));
    act(`DSW_MODE_SOURCE, r, NONE);
    chk(32'({errorLed, controlSource}), 32'hD);
    rdchk(`DSW_OFS_STATUS, 32'h3, 1'b0);
    wr(`DSW_OFS_MASK, 32'h2);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h1);
    wr(`DSW_OFS_STATUS, 32'h2);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0);
    for (int p = 0; p <= 3; p++) begin
      g = goodHigh;
      act(`DSW_MODE_TRAVEL, 8'(p), {8'h03, 8'(p)});
      chk(32'({errorLed, openOnTorque, closeOnTorque}), 32'(p));
      chk(32'(goodHigh > g), 32'h1);
    end
    rdchk(`DSW_OFS_CONFIG, 32'h001D0300, 1'b0);
    g = goodHigh;
    act(`DSW_MODE_TRAVEL, 8'h04, NONE);
    chk(32'(errorLed), 32'h1);
    chk(32'(goodHigh - g), 32'h0);
    repeat (4) begin
      m = 5'(4 + $urandom_range(27));
      r = 8'($urandom);
      act(m, r, {3'h0, m, r});
    end
    act(`DSW_MODE_DIRECT, 8'h01, 16'h2000);
    rdchk(`DSW_OFS_CONFIG, 32'h0, 1'b0);
    act(`DSW_MODE_DIRECT, 8'h02, 16'h4000);
    act(`DSW_MODE_DIRECT, 8'h03, 16'h8000);
    act(`DSW_MODE_DIRECT, 8'h04, NONE);
    chk(32'(errorLed), 32'h1);
    i_dsw_switch_model.lines(1'b0, 1'b0, 1'b0);
    act(5'h04, 8'h55, NONE);
    i_dsw_switch_model.lines(1'b1, 1'b0, 1'b0);
    wr(`DSW_OFS_CTRL, 32'h0);
    act(5'h04, 8'h56, NONE);
    wr(`DSW_OFS_CTRL, 32'h1);
    act(`DSW_MODE_RUN, 8'h00, NONE);
    act(`DSW_MODE_RUN, 8'hFF, NONE);
    chk(32'({errorLed, stationAddr}), 32'h100);
    act(`DSW_MODE_RUN, 8'hFE, 16'h00FE);
    chk(32'({errorLed, inSetup, stationAddr}), 32'hFE);
    per(16);
    chk(expq.size(), 32'h0);
    tally_and_finish();
  end
endmodule
